/* File: rtl/scwg_pkg.sv */
// constants and types shared by the serial command and write guard logic
package scwg_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] SCWG_OP_LATCH_SET   = 8'h06; // set write latch
  localparam logic [7:0] SCWG_OP_LATCH_CLEAR = 8'h04; // clear write latch
  localparam logic [7:0] SCWG_OP_STAT_READ   = 8'h05; // status read
  localparam logic [7:0] SCWG_OP_STAT_WRITE  = 8'h01; // status write
  localparam logic [7:0] SCWG_OP_READ        = 8'h03; // memory read
  localparam logic [7:0] SCWG_OP_FAST_FETCH  = 8'h0b; // fast read
  localparam logic [7:0] SCWG_OP_WRITE       = 8'h02; // memory write
  localparam logic [7:0] SCWG_OP_SLEEP       = 8'hb9; // sleep entry
  localparam logic [7:0] SCWG_OP_IDENT       = 8'h9f; // identity read

  // ----------------------------------------------------------------
  // status field positions and reset value
  // ----------------------------------------------------------------
  localparam int         SCWG_BIT_PIN_GUARD = 7; // guard pin enable
  localparam int         SCWG_BIT_GUARD_HI  = 3; // upper block bit
  localparam int         SCWG_BIT_GUARD_LO  = 2; // lower block bit
  localparam int         SCWG_BIT_LATCH     = 1; // write latch flag
  localparam logic [7:0] SCWG_STATUS_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // protected range lower bounds, 14-bit address
  // ----------------------------------------------------------------
  localparam logic [13:0] SCWG_PROT_QUARTER = 14'h3000;
  localparam logic [13:0] SCWG_PROT_HALF    = 14'h2000;
  localparam logic [13:0] SCWG_PROT_ALL     = 14'h0000;

  // ----------------------------------------------------------------
  // decoded command kinds
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SCWG_CMD_NONE, SCWG_CMD_LATCH_SET, SCWG_CMD_LATCH_CLEAR,
    SCWG_CMD_STAT_READ, SCWG_CMD_STAT_WRITE, SCWG_CMD_READ,
    SCWG_CMD_FAST_FETCH, SCWG_CMD_WRITE, SCWG_CMD_SLEEP,
    SCWG_CMD_IDENT, SCWG_CMD_INVALID
  } scwg_cmd_type;

  // memory write request handed to the array side
  typedef struct packed {
    logic        valid; // one-cycle strobe
    logic [13:0] addr;  // byte address
    logic [7:0]  data;  // byte to store
  } scwg_mem_write_type;

endpackage

/* File: rtl/scwg_core.sv */
// serial command decoder, write latch and status guard
`timescale 1ns/10ps
`default_nettype none
module scwg_core (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         cs_n_i,      // chip select
  input  wire logic                         sck_i,       // serial clock
  input  wire logic                         si_i,        // serial data in
  input  wire logic                         guard_n_i,   // guard pin
  input  wire logic [7:0]                   nv_status_i, // stored bits
  input  wire logic                         waking_i,    // sleep recovery
  output logic                              so_o,        // serial out
  output logic                              so_oe_o,     // out enable
  output scwg_pkg::scwg_cmd_type            cmd_o,       // decoded cmd
  output logic                              cmd_valid_o, // cmd strobe
  output logic [7:0]                        status_o,    // status view
  output logic                              nv_store_o,  // persist strobe
  output scwg_pkg::scwg_mem_write_type      mem_wr_o     // array write
);
  import scwg_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cs_sync;   // chip select stages
  logic [2:0] sck_sync;  // clock stages
  logic [2:0] si_sync;   // data stages
  logic [2:0] wp_sync;   // guard pin stages
  logic       cs_lvl;    // filtered select level
  logic       sck_lvl;   // filtered clock level
  logic       si_lvl;    // filtered data level
  logic       wp_lvl;    // filtered guard level

  // three stages, level moves only when stages 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_sync  <= 3'h7;
      sck_sync <= 3'h0;
      si_sync  <= 3'h0;
      wp_sync  <= 3'h7;
    end else begin
      cs_sync  <= {cs_sync[1:0], cs_n_i};
      sck_sync <= {sck_sync[1:0], sck_i};
      si_sync  <= {si_sync[1:0], si_i};
      wp_sync  <= {wp_sync[1:0], guard_n_i};
    end
  end

  // filtered levels
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_lvl  <= 1'b1;
      sck_lvl <= 1'b0;
      si_lvl  <= 1'b0;
      wp_lvl  <= 1'b1;
    end else begin
      if (cs_sync[1] == cs_sync[2])
        cs_lvl <= cs_sync[2];
      if (sck_sync[1] == sck_sync[2])
        sck_lvl <= sck_sync[2];
      if (si_sync[1] == si_sync[2])
        si_lvl <= si_sync[2];
      if (wp_sync[1] == wp_sync[2])
        wp_lvl <= wp_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic cs_prev;   // last select level
  logic sck_prev;  // last clock level
  logic cs_fall;   // frame start
  logic cs_rise;   // frame end
  logic sck_rise;  // sample point
  logic sck_fall;  // drive point
  logic active;    // frame open

  // previous levels; a clock edge counts only inside a frame
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_prev  <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      cs_prev  <= cs_lvl;
      sck_prev <= sck_lvl;
    end
  end

  assign cs_fall  = cs_prev & ~cs_lvl;
  assign cs_rise  = ~cs_prev & cs_lvl;
  assign active   = ~cs_lvl & ~cs_prev;
  assign sck_rise = active & sck_lvl & ~sck_prev;
  assign sck_fall = active & ~sck_lvl & sck_prev;

  // ----------------------------------------------------------------
  // bit and byte counting
  // ----------------------------------------------------------------
  logic [2:0]  bit_cnt;   // bit within byte
  logic [7:0]  shift_in;  // receive shift
  logic [7:0]  next_byte; // byte with new bit
  logic        byte_done; // eighth bit sampled
  logic [2:0]  byte_cnt;  // bytes seen, saturates at 7

  assign next_byte = {shift_in[6:0], si_lvl};
  assign byte_done = sck_rise & (bit_cnt == 3'h7);

  // msb-first shift, counters restart with each frame
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_fall) begin
      bit_cnt  <= 3'h0;
      shift_in <= 8'h00;
      byte_cnt <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= next_byte;
      if (byte_done && byte_cnt != 3'h7)
        byte_cnt <= byte_cnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  scwg_cmd_type cmd;      // command of this frame
  scwg_cmd_type next_cmd; // decode of received byte

  // nine known codes; reserved and others count as invalid
  always_comb begin
    unique case (next_byte)
      SCWG_OP_LATCH_SET:   next_cmd = SCWG_CMD_LATCH_SET;
      SCWG_OP_LATCH_CLEAR: next_cmd = SCWG_CMD_LATCH_CLEAR;
      SCWG_OP_STAT_READ:   next_cmd = SCWG_CMD_STAT_READ;
      SCWG_OP_STAT_WRITE:  next_cmd = SCWG_CMD_STAT_WRITE;
      SCWG_OP_READ:        next_cmd = SCWG_CMD_READ;
      SCWG_OP_FAST_FETCH:  next_cmd = SCWG_CMD_FAST_FETCH;
      SCWG_OP_WRITE:       next_cmd = SCWG_CMD_WRITE;
      SCWG_OP_SLEEP:       next_cmd = SCWG_CMD_SLEEP;
      SCWG_OP_IDENT:       next_cmd = SCWG_CMD_IDENT;
      default:             next_cmd = SCWG_CMD_INVALID;
    endcase
  end

  // only the first byte of a frame is a command
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_fall) begin
      cmd         <= SCWG_CMD_NONE;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      if (byte_done && byte_cnt == 3'h0) begin
        cmd         <= next_cmd;
        cmd_valid_o <= 1'b1;
      end
    end
  end

  assign cmd_o = cmd;

  // ----------------------------------------------------------------
  // write latch and status register
  // ----------------------------------------------------------------
  logic       wr_latch;    // write latch flag
  logic       pin_guard;   // guard pin enable
  logic [1:0] block_guard; // block protect bits
  logic       stat_ok;     // status write allowed
  logic       stat_take;   // full data byte received
  logic       nv_load;     // restore pending

  // guard pin matters only with the enable bit set
  assign stat_ok = wr_latch & ~(pin_guard & ~wp_lvl);
  assign stat_take = byte_done && byte_cnt == 3'h1 &&
                     cmd == SCWG_CMD_STAT_WRITE;

  // latch: set by its command only, cleared at end of write frames
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_latch <= 1'b0;
    end else if (cs_rise) begin
      if (cmd == SCWG_CMD_LATCH_SET)
        wr_latch <= 1'b1;
      else if (cmd == SCWG_CMD_LATCH_CLEAR ||
               cmd == SCWG_CMD_STAT_WRITE ||
               cmd == SCWG_CMD_WRITE)
        wr_latch <= 1'b0;
    end
  end

  // block bits come from the nonvolatile store after reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_guard   <= 1'b0;
      block_guard <= 2'h0;
    end else if (stat_take && stat_ok) begin
      // status bit 1 of the data byte is dropped on purpose
      pin_guard   <= next_byte[SCWG_BIT_PIN_GUARD];
      block_guard <= {next_byte[SCWG_BIT_GUARD_HI],
                      next_byte[SCWG_BIT_GUARD_LO]};
    end else if (nv_load) begin
      pin_guard   <= nv_status_i[SCWG_BIT_PIN_GUARD];
      block_guard <= {nv_status_i[SCWG_BIT_GUARD_HI],
                      nv_status_i[SCWG_BIT_GUARD_LO]};
    end
  end

  // one-shot restore right after reset release
  always_ff @(posedge clk_i) begin
    if (reset_i)
      nv_load <= 1'b1;
    else
      nv_load <= 1'b0;
  end

  // persist strobe follows an accepted status write
  always_ff @(posedge clk_i) begin
    if (reset_i)
      nv_store_o <= 1'b0;
    else
      nv_store_o <= stat_take & stat_ok;
  end

  // fixed bits read zero; bit 0 only uncertain while waking
  always_comb begin
    status_o = SCWG_STATUS_RESET;
    status_o[SCWG_BIT_PIN_GUARD] = pin_guard;
    status_o[SCWG_BIT_GUARD_HI]  = block_guard[1];
    status_o[SCWG_BIT_GUARD_LO]  = block_guard[0];
    status_o[SCWG_BIT_LATCH]     = wr_latch;
    status_o[0]                  = waking_i;
  end

  // ----------------------------------------------------------------
  // status read output
  // ----------------------------------------------------------------
  logic [7:0] shift_out; // transmit shift
  logic       so_run;    // driving status byte

  // load on the command byte, shift on falling edges, msb first
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_rise || cs_fall) begin
      shift_out <= 8'h00;
      so_run    <= 1'b0;
      so_o      <= 1'b0;
    end else if (byte_done && byte_cnt == 3'h0 &&
                 next_cmd == SCWG_CMD_STAT_READ) begin
      shift_out <= status_o;
      so_run    <= 1'b1;
    end else if (sck_fall && so_run) begin
      so_o      <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
      // one byte only, tristate once the ninth edge passes
      if (byte_cnt == 3'h2 && bit_cnt == 3'h0)
        so_run <= 1'b0;
    end
  end

  // invalid commands keep the pin released
  assign so_oe_o = so_run & active & (cmd == SCWG_CMD_STAT_READ);

  // ----------------------------------------------------------------
  // memory write guard
  // ----------------------------------------------------------------
  logic [13:0] wr_addr;  // burst address
  logic        wr_stop;  // burst halted
  logic        prot_hit; // address protected
  logic [13:0] prot_lo;  // lowest protected address

  // block bits pick the protected tail of the array
  always_comb begin
    unique case (block_guard)
      2'h0: prot_lo = SCWG_PROT_ALL;     // unused, see prot_hit
      2'h1: prot_lo = SCWG_PROT_QUARTER;
      2'h2: prot_lo = SCWG_PROT_HALF;
      2'h3: prot_lo = SCWG_PROT_ALL;
    endcase
  end

  assign prot_hit = (block_guard != 2'h0) && (wr_addr >= prot_lo);

  // address from bytes 2 and 3, data bytes thereafter
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_fall) begin
      wr_addr  <= 14'h0000;
      wr_stop  <= 1'b0;
      mem_wr_o <= '0;
    end else begin
      mem_wr_o.valid <= 1'b0;
      if (byte_done && cmd == SCWG_CMD_WRITE) begin
        if (byte_cnt == 3'h1)
          wr_addr[13:8] <= next_byte[5:0];
        else if (byte_cnt == 3'h2)
          wr_addr[7:0] <= next_byte;
        else if (!wr_stop) begin
          if (!wr_latch || prot_hit) begin
            wr_stop <= 1'b1;
          end else begin
            mem_wr_o.valid <= 1'b1;
            mem_wr_o.addr  <= wr_addr;
            mem_wr_o.data  <= next_byte;
            wr_addr        <= wr_addr + 14'h0001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_status_take;
    stat_take && stat_ok;
  endsequence

  AST_LATCH_RESET: assert property (@(posedge clk_i)
    reset_i |=> !wr_latch)
    else $error("latch not clear after reset");
  AST_LATCH_SET: assert property (@(posedge clk_i) disable iff (reset_i)
    cs_rise && cmd == SCWG_CMD_LATCH_SET |=> wr_latch)
    else $error("latch set command ignored");
  AST_LATCH_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
    cs_rise && (cmd == SCWG_CMD_WRITE || cmd == SCWG_CMD_STAT_WRITE ||
    cmd == SCWG_CMD_LATCH_CLEAR) |=> !wr_latch)
    else $error("latch not cleared at frame end");
  AST_LATCH_ONLY_CMD: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(wr_latch) |-> $past(cmd) == SCWG_CMD_LATCH_SET)
    else $error("latch rose without its command");
  AST_STAT_GUARD: assert property (@(posedge clk_i) disable iff (reset_i)
    stat_take && pin_guard && !wp_lvl |=> $stable(block_guard))
    else $error("status written while pin guarded");
  AST_STAT_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
    seq_status_take |=> block_guard == $past(next_byte[3:2]))
    else $error("status write not loaded");
  AST_FIXED_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    status_o[6:4] == 3'h0 && (waking_i || !status_o[0]))
    else $error("fixed status bits not zero");
  AST_NO_PROT_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
    mem_wr_o.valid |-> $past(wr_latch) && !$past(prot_hit))
    else $error("guarded memory write issued");
  AST_INVALID_QUIET: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd == SCWG_CMD_INVALID |-> !so_oe_o && !mem_wr_o.valid)
    else $error("invalid command drove output");

endmodule
`default_nettype wire

/* File: bench/scwg_master.sv */
// serial bus master model that frames commands towards the guard block
`timescale 1ns/10ps
`default_nettype none
module scwg_master (
  input  wire logic clk_i,  // system clock, used only to pace the link
  input  wire logic so_i,   // serial data from the device
  output logic      cs_n_o, // chip select, active low
  output logic      sck_o,  // link clock, mode 0, still between frames
  output logic      si_o    // serial data to the device
);
  int half = 8; // clk cycles per link half period, 64 ns period at 8

  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // one selected frame: nbits clocked from w, msb first
  // ----------------------------------------------------------------
  task automatic frame(input logic [47:0] w, input int nbits,
                       output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    wait_clk(half);
    for (i = 0; i < nbits; i++) begin
      si_o <= w[47 - i];
      wait_clk(half);
      sck_o <= 1'b1;
      rx = {rx[6:0], so_i};
      wait_clk(half);
      sck_o <= 1'b0;
    end
    wait_clk(half);
    cs_n_o <= 1'b1;
    // released line shows the inverse so a stale value cannot pass
    si_o <= ~si_o;
    wait_clk(4 * half);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the serial command and write guard block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; \
  if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t got %h expected %h", $time, got, exp); \
  end end
module tb;
  import scwg_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               clk_i = 1'b0;
  logic               reset_i;
  logic               cs_n_i, sck_i, si_i;
  logic               guard_n_i;
  logic [7:0]         nv_status_i;
  logic               waking_i;
  logic               so_o, so_oe_o, cmd_valid_o, nv_store_o;
  scwg_cmd_type       cmd_o;
  logic [7:0]         status_o;
  scwg_mem_write_type mem_wr_o, last_wr;
  int                 n_errors = 0, n_compared = 0;
  int                 n_wr = 0, n_store = 0, n_cmd = 0, k;
  logic               oe_seen = 1'b0;
  logic [7:0]         rx;

  typedef struct {
    logic [7:0]   op;    // opcode sent alone in a frame
    scwg_cmd_type cmd;   // decoded kind
    logic         latch; // write latch flag after the frame
  } scwg_row_type;
  scwg_row_type rows [15] = '{
    '{8'h06, SCWG_CMD_LATCH_SET, 1'b1}, '{8'h05, SCWG_CMD_STAT_READ, 1'b1},
    '{8'h03, SCWG_CMD_READ, 1'b1}, '{8'h0b, SCWG_CMD_FAST_FETCH, 1'b1},
    '{8'h9f, SCWG_CMD_IDENT, 1'b1}, '{8'hc3, SCWG_CMD_INVALID, 1'b1},
    '{8'hc2, SCWG_CMD_INVALID, 1'b1}, '{8'h5a, SCWG_CMD_INVALID, 1'b1},
    '{8'h5b, SCWG_CMD_INVALID, 1'b1}, '{8'h04, SCWG_CMD_LATCH_CLEAR, 1'b0},
    '{8'h06, SCWG_CMD_LATCH_SET, 1'b1}, '{8'h01, SCWG_CMD_STAT_WRITE, 1'b0},
    '{8'h06, SCWG_CMD_LATCH_SET, 1'b1}, '{8'h02, SCWG_CMD_WRITE, 1'b0},
    '{8'hb9, SCWG_CMD_SLEEP, 1'b0}};

  always #2 clk_i = ~clk_i; // 250 MHz

  // a released output shows the inverse so a stale bit cannot pass
  scwg_master u_master (.clk_i(clk_i), .so_i(so_oe_o ? so_o : ~so_o),
                        .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i));

  scwg_core uut (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i),
                 .sck_i(sck_i), .si_i(si_i), .guard_n_i(guard_n_i),
                 .nv_status_i(nv_status_i), .waking_i(waking_i),
                 .so_o(so_o), .so_oe_o(so_oe_o), .cmd_o(cmd_o),
                 .cmd_valid_o(cmd_valid_o), .status_o(status_o),
                 .nv_store_o(nv_store_o), .mem_wr_o(mem_wr_o));

  // ----------------------------------------------------------------
  // monitors of the one-cycle strobes and the output enable
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (mem_wr_o.valid === 1'b1) begin
      n_wr++;
      last_wr = mem_wr_o;
    end
    if (nv_store_o === 1'b1) n_store++;
    if (cmd_valid_o === 1'b1) n_cmd++;
    if (so_oe_o === 1'b1) oe_seen = 1'b1;
  end

  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tx(input logic [47:0] w, input int nb);
    u_master.frame(w, nb, rx);
  endtask

  // latch set always goes out in its own frame
  task automatic latch_set_cmd;
    tx({8'h06, 40'h0}, 8);
  endtask

  task automatic do_reset(input logic [7:0] nv);
    @(posedge clk_i);
    nv_status_i <= nv;
    reset_i     <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // watchdog, well above the expected run of some 8k cycles
  // ----------------------------------------------------------------
  initial begin
    #320000;
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    guard_n_i = 1'b1;
    waking_i = 1'b0;
    nv_status_i = 8'h00;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    `CHK(status_o, 8'h00)
    `CHK(so_oe_o, 1'b0)
    for (k = 0; k < 15; k++) begin
      tx({rows[k].op, 40'h0}, 8);
      `CHK(cmd_o, rows[k].cmd)
      `CHK(status_o[1], rows[k].latch)
    end
    `CHK(n_cmd, 15)
    // stored bits return after reset, fixed bits stay zero
    do_reset(8'hff);
    `CHK(status_o, 8'h8c)
    latch_set_cmd();
    oe_seen = 1'b0;
    tx({8'h05, 40'h0}, 16);
    `CHK(rx, 8'h8e)
    `CHK(oe_seen, 1'b1)
    // all blocks guarded: write refused, latch still dropped
    tx({8'h02, 8'h00, 8'h10, 8'haa, 16'h0}, 32);
    `CHK(n_wr, 0)
    `CHK(status_o, 8'h8c)
    @(posedge clk_i);
    guard_n_i <= 1'b0;
    latch_set_cmd();
    tx({8'h01, 8'h00, 32'h0}, 16);
    `CHK(status_o, 8'h8c)
    `CHK(n_store, 0)
    @(posedge clk_i);
    guard_n_i <= 1'b1;
    latch_set_cmd();
    tx({8'h01, 8'h73, 32'h0}, 16);
    `CHK(status_o, 8'h00)
    `CHK(n_store, 1)
    @(posedge clk_i);
    guard_n_i <= 1'b0;
    latch_set_cmd();
    tx({8'h01, 8'h84, 32'h0}, 16);
    `CHK(status_o, 8'h84)
    // data byte cut short leaves the status alone, pin released
    @(posedge clk_i);
    guard_n_i <= 1'b1;
    latch_set_cmd();
    tx({8'h01, 8'h0c, 32'h0}, 12);
    `CHK(status_o[7:2], 6'h21)
    // slow master, burst runs into the upper quarter and stops
    u_master.half = 12;
    latch_set_cmd();
    tx({8'h02, 8'hef, 8'hff, 8'hd1, 8'hd2, 8'h00}, 40);
    u_master.half = 8;
    `CHK(n_wr, 1)
    `CHK(last_wr.addr, 14'h2fff)
    `CHK(last_wr.data, 8'hd1)
    tx({8'h02, 8'h00, 8'h00, 8'h55, 16'h0}, 32);
    `CHK(n_wr, 1)
    oe_seen = 1'b0;
    tx({8'hc3, 8'h05, 8'h00, 24'h0}, 24);
    `CHK(oe_seen, 1'b0)
    `CHK(status_o, 8'h84)
    @(posedge clk_i);
    waking_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(status_o[0], 1'b1)
    waking_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(status_o[0], 1'b0)
    `CHK(n_cmd, 30)
    stop_test();
  end
endmodule
`default_nettype wire
